// ### tpu_defines.svh
// Register map, field positions, reset values and widths for the timer unit
`ifndef TPU_DEFINES_SVH
`define TPU_DEFINES_SVH

// ============================================================
// Register word indexes on the plain register port
`define TPU_ADDR_CTRL 8'h00
`define TPU_ADDR_COUNT 8'h01
`define TPU_ADDR_MOD 8'h02
`define TPU_ADDR_CH_BASE 8'h04

// ============================================================
// Timer control word fields
`define TPU_CTRL_PS_LSB 0
`define TPU_CTRL_PS_MSB 2
`define TPU_CTRL_SRC_LSB 3
`define TPU_CTRL_SRC_MSB 4
`define TPU_CTRL_CENTER 5
`define TPU_CTRL_OVF_IE 6
`define TPU_CTRL_OVF_FLAG 7

// ============================================================
// Channel control word fields
`define TPU_CH_MODE_LSB 0
`define TPU_CH_MODE_MSB 1
`define TPU_CH_SEL_LSB 2
`define TPU_CH_SEL_MSB 3
`define TPU_CH_IE 6
`define TPU_CH_FLAG 7

// ============================================================
// Reset values and widths
`define TPU_MOD_RESET 16'hffff
`define TPU_WORD_ZERO 16'h0000
`define TPU_PRE_WIDTH 7

`endif

// ### tpu_pkg.sv
// Types shared by the timer unit and its channels
package tpu_pkg;

  // Counter clock source; off stops the counter
  typedef enum logic [1:0] {
    TPU_SRC_OFF,
    TPU_SRC_BUS,
    TPU_SRC_FIXED,
    TPU_SRC_PIN
  } tpu_src_type;

  // Channel function
  typedef enum logic [1:0] {
    TPU_CH_OFF,
    TPU_CH_CAPTURE,
    TPU_CH_COMPARE,
    TPU_CH_PWM
  } tpu_mode_type;

  // Channel configuration as one carrier
  typedef struct packed {
    logic irq_en;
    tpu_mode_type mode;
    logic [1:0] sel;
  } tpu_chcfg_type;

  // Counter timing strobes handed to every channel
  typedef struct packed {
    logic [15:0] count;
    logic fresh;
    logic boundary;
    logic center;
  } tpu_time_type;

endpackage

// ### tpu_channel.sv
// One timer channel: capture, compare or pulse-width output
`timescale 1ns/1ps
`default_nettype none
`include "tpu_defines.svh"
module tpu_channel (
  input wire logic clk,
  input wire logic reset,
  input wire tpu_pkg::tpu_time_type tm,
  input wire tpu_pkg::tpu_chcfg_type cfg,
  input wire logic val_wr,
  input wire logic [15:0] wdata,
  input wire logic flag_clr,
  input wire logic pin_in,
  output logic [15:0] val_q,
  output logic flag_q,
  output logic irq_q,
  output logic pin_out_q,
  output logic pin_oe_n_q
);
  logic [15:0] val_act_q;
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic rise;
  logic fall;
  logic cap_hit;
  logic match;
  logic pwm_on;
  logic event_hit;
  logic cmp_out;

  // ============================================================
  // Pin input, two stages before any edge logic looks at it
  always_ff @(posedge clk) begin
    sync1_q <= pin_in;
    sync2_q <= sync1_q;
    prev_q <= sync2_q;
  end

  // Edge selection: 1 rising, 2 falling, 3 either
  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;
  assign cap_hit = (cfg.mode == tpu_pkg::TPU_CH_CAPTURE) &&
                   ((cfg.sel[0] && rise) || (cfg.sel[1] && fall));
  assign match = tm.fresh && (tm.count == val_act_q);
  // polarity select, sel[0] set means high-true pulse
  assign pwm_on = (tm.count < val_act_q) ~^ cfg.sel[0];
  assign event_hit = cap_hit ||
    (match && (cfg.mode == tpu_pkg::TPU_CH_COMPARE ||
               cfg.mode == tpu_pkg::TPU_CH_PWM));
  // action 1 toggle, 2 clear, 3 set, 0 pin untouched
  assign cmp_out = (cfg.sel == 2'h1) ? ~pin_out_q :
                   (cfg.sel == 2'h2) ? 1'b0 :
                   (cfg.sel == 2'h3) ? 1'b1 : pin_out_q;

  // ============================================================
  // Channel value: capture latches the count, software writes buffer
  always_ff @(posedge clk) begin
    if (reset) begin
      val_q <= `TPU_WORD_ZERO;
    end else if (cap_hit) begin
      val_q <= tm.count;
    end else if (val_wr) begin
      val_q <= wdata;
    end
  end

  // duty buffer moves in only at the period boundary
  // Compare and capture need the value at once, so they bypass the buffer
  always_ff @(posedge clk) begin
    if (reset) begin
      val_act_q <= `TPU_WORD_ZERO;
    end else if (cfg.mode != tpu_pkg::TPU_CH_PWM || tm.boundary) begin
      val_act_q <= val_q;
    end
  end

  // channel flag, a new event beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      flag_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      flag_q <= event_hit | (flag_q & ~flag_clr);
      irq_q <= cfg.irq_en & (event_hit | (flag_q & ~flag_clr));
    end
  end

  // pin driven only in compare or pwm, else given back to the port
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_out_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end else begin
      pin_oe_n_q <= ~(cfg.mode == tpu_pkg::TPU_CH_COMPARE ||
                      cfg.mode == tpu_pkg::TPU_CH_PWM);
      if (cfg.mode == tpu_pkg::TPU_CH_PWM) begin
        pin_out_q <= pwm_on;
      end else if (cfg.mode == tpu_pkg::TPU_CH_COMPARE && match) begin
        pin_out_q <= cmp_out;
      end
    end
  end
endmodule
`default_nettype wire

// ### tpu_timer.sv
// Timer and pulse-width unit: counter, prescaler, register port, channels
//
// Overview of operation
// - All timing comes from one 16-bit counter behind prescaler and modulus.
// - Counter counts up, or up and down in center-aligned mode.
// - A 16-bit modulus register sets the counting range and period.
// - One control bit puts every channel not set to off into center-aligned mode.
// - Prescaler divides the source by 1, 2, 4 up to 128.
// - Counter source chosen among bus clock, fixed clock, external pin.
// - Fixed system clock is the external reference divided by two.
// - Each channel is capture, compare or edge-aligned pulse output.
// - Capture latches the count on rising, falling or either edge.
// - Compare sets, clears or toggles the pin on a count match.
// - Pulse output polarity is selectable high-true or low-true.
// - One interrupt per channel plus one for terminal count.
// - Unit one has five channels, four pinned; unit two three, one.
// - Each pinned channel owns one pin, returned to the port when unused.
`timescale 1ns/1ps
`default_nettype none
`include "tpu_defines.svh"
module tpu_timer #(
  // unit one uses 5 and 4, unit two uses 3 and 1
  parameter int CHANNELS = 5,
  parameter int PINNED = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_q,
  input wire logic external_reference_clock,
  input wire logic ext_clock_pin,
  input wire logic [PINNED-1:0] timer_channel_pin_in,
  output logic [PINNED-1:0] timer_channel_pin_out,
  output logic [PINNED-1:0] timer_channel_pin_oe_n,
  output logic [CHANNELS-1:0] channel_irq_q,
  output logic overflow_irq_q
);

  // ============================================================
  // Helpers

  // Prescaler tap mask: ratio 2**ps needs the low ps bits all ones
  function automatic logic [`TPU_PRE_WIDTH-1:0] pre_mask(
    input logic [2:0] ps
  );
    pre_mask = 7'h7f >> (3'h7 - ps);
  endfunction

  // Channel slot of a register index
  function automatic logic [6:0] ch_slot(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - `TPU_ADDR_CH_BASE;
    ch_slot = rel[7:1];
  endfunction

  // ============================================================
  // Control state
  logic [2:0] ps_q;
  tpu_pkg::tpu_src_type src_q;
  logic center_q;
  logic ovf_ie_q;
  logic ovf_flag_q;
  logic [15:0] mod_q;
  logic [15:0] mod_act_q;
  logic [15:0] count_q;
  logic down_q;
  logic fresh_q;
  logic boundary_q;
  logic [`TPU_PRE_WIDTH-1:0] pre_q;
  tpu_pkg::tpu_chcfg_type cfg_q [CHANNELS];

  // ============================================================
  // Clock source pins, two stages each before use
  logic ref1_q;
  logic ref2_q;
  logic ref3_q;
  logic half_q;
  logic pin1_q;
  logic pin2_q;
  logic pin3_q;

  always_ff @(posedge clk) begin
    ref1_q <= external_reference_clock;
    ref2_q <= ref1_q;
    ref3_q <= ref2_q;
    pin1_q <= ext_clock_pin;
    pin2_q <= pin1_q;
    pin3_q <= pin2_q;
  end

  // fixed clock ticks on every second reference rising edge
  // The reference must stay well below half of clk to be seen at all
  logic ref_rise;
  logic fixed_tick;
  logic pin_tick;
  assign ref_rise = ref2_q & ~ref3_q;
  assign fixed_tick = ref_rise & half_q;
  assign pin_tick = pin2_q & ~pin3_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      half_q <= 1'b0;
    end else if (ref_rise) begin
      half_q <= ~half_q;
    end
  end

  // ============================================================
  // Source select and prescaler
  logic src_tick;
  logic count_tick;
  // independent source choice, off halts counting
  assign src_tick = (src_q == tpu_pkg::TPU_SRC_BUS) ? 1'b1 :
                    (src_q == tpu_pkg::TPU_SRC_FIXED) ? fixed_tick :
                    (src_q == tpu_pkg::TPU_SRC_PIN) ? pin_tick : 1'b0;
  // one count per 2**ps source ticks
  assign count_tick = src_tick &&
                      ((pre_q & pre_mask(ps_q)) == pre_mask(ps_q));

  always_ff @(posedge clk) begin
    if (reset || src_q == tpu_pkg::TPU_SRC_OFF) begin
      pre_q <= '0;
    end else if (src_tick) begin
      pre_q <= pre_q + 7'h01;
    end
  end

  // ============================================================
  // Register port decode
  logic wr_ctrl;
  logic wr_count;
  logic wr_mod;
  logic ch_hit;
  logic [6:0] slot;
  logic ovf_clr;
  assign wr_ctrl = reg_wr && reg_addr == `TPU_ADDR_CTRL;
  assign wr_count = reg_wr && reg_addr == `TPU_ADDR_COUNT;
  assign wr_mod = reg_wr && reg_addr == `TPU_ADDR_MOD;
  assign slot = ch_slot(reg_addr);
  assign ch_hit = reg_addr >= `TPU_ADDR_CH_BASE &&
                  slot < 7'(CHANNELS);
  assign ovf_clr = wr_ctrl && reg_wdata[`TPU_CTRL_OVF_FLAG];

  // ============================================================
  // Counter next state
  logic at_top;
  logic wrap_up;
  logic turn_down;
  logic end_down;
  logic period_end;
  assign at_top = count_q >= mod_act_q;
  // free-running up count wraps to zero after the modulus
  assign wrap_up = count_tick && !center_q && at_top;
  // center mode turns at the modulus and ends the period at zero
  assign turn_down = count_tick && center_q && !down_q && at_top &&
                     mod_act_q != `TPU_WORD_ZERO;
  assign end_down = count_tick && center_q && down_q &&
                    count_q <= 16'h0001;
  assign period_end = wrap_up || end_down ||
    (count_tick && center_q && mod_act_q == `TPU_WORD_ZERO);

  // the single counter every channel works from
  // A software write restarts the count and the period
  always_ff @(posedge clk) begin
    if (reset || wr_count) begin
      count_q <= `TPU_WORD_ZERO;
      down_q <= 1'b0;
    end else if (period_end) begin
      count_q <= `TPU_WORD_ZERO;
      down_q <= 1'b0;
    end else if (turn_down) begin
      count_q <= count_q - 16'h0001;
      down_q <= 1'b1;
    end else if (count_tick) begin
      count_q <= down_q ? count_q - 16'h0001 : count_q + 16'h0001;
    end
  end

  // Strobes in the same cycle as the new count, seen by every channel
  always_ff @(posedge clk) begin
    if (reset) begin
      fresh_q <= 1'b0;
      boundary_q <= 1'b0;
    end else begin
      fresh_q <= count_tick;
      boundary_q <= period_end | wr_count;
    end
  end

  // ============================================================
  // Timer control word and modulus
  // one bit switches every channel not set to off to center alignment
  always_ff @(posedge clk) begin
    if (reset) begin
      ps_q <= 3'h0;
      src_q <= tpu_pkg::TPU_SRC_OFF;
      center_q <= 1'b0;
      ovf_ie_q <= 1'b0;
    end else if (wr_ctrl) begin
      ps_q <= reg_wdata[`TPU_CTRL_PS_MSB:`TPU_CTRL_PS_LSB];
      src_q <= tpu_pkg::tpu_src_type'(
        reg_wdata[`TPU_CTRL_SRC_MSB:`TPU_CTRL_SRC_LSB]);
      center_q <= reg_wdata[`TPU_CTRL_CENTER];
      ovf_ie_q <= reg_wdata[`TPU_CTRL_OVF_IE];
    end
  end

  // terminal count flag, a new period end beats the clear
  always_ff @(posedge clk) begin
    if (reset) begin
      ovf_flag_q <= 1'b0;
      overflow_irq_q <= 1'b0;
    end else begin
      ovf_flag_q <= period_end | (ovf_flag_q & ~ovf_clr);
      overflow_irq_q <= ovf_ie_q & (period_end | (ovf_flag_q & ~ovf_clr));
    end
  end

  // software modulus, held until the period ends
  always_ff @(posedge clk) begin
    if (reset) begin
      mod_q <= `TPU_MOD_RESET;
    end else if (wr_mod) begin
      mod_q <= reg_wdata;
    end
  end

  // active modulus loads at the boundary or while stopped
  always_ff @(posedge clk) begin
    if (reset) begin
      mod_act_q <= `TPU_MOD_RESET;
    end else if (period_end || src_q == tpu_pkg::TPU_SRC_OFF) begin
      mod_act_q <= mod_q;
    end
  end

  // ============================================================
  // Channels
  tpu_pkg::tpu_time_type tm;
  assign tm.count = count_q;
  assign tm.fresh = fresh_q;
  assign tm.boundary = boundary_q;
  assign tm.center = center_q;

  logic [15:0] ch_val [CHANNELS];
  logic [CHANNELS-1:0] ch_flag;
  logic [CHANNELS-1:0] ch_pin_in;
  logic [CHANNELS-1:0] ch_pin_out;
  logic [CHANNELS-1:0] ch_pin_oe_n;
  logic [CHANNELS-1:0] ch_irq;

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
      logic ctl_wr;
      logic val_wr;
      assign ctl_wr = reg_wr && ch_hit && slot == 7'(gi) && !reg_addr[0];
      assign val_wr = reg_wr && ch_hit && slot == 7'(gi) && reg_addr[0];

      // channels past the pinned count have no pin
      if (gi < PINNED) begin : g_pin
        assign ch_pin_in[gi] = timer_channel_pin_in[gi];
        assign timer_channel_pin_out[gi] = ch_pin_out[gi];
        assign timer_channel_pin_oe_n[gi] = ch_pin_oe_n[gi];
      end else begin : g_nopin
        assign ch_pin_in[gi] = 1'b0;
      end

      // per-channel mode, compare and capture, pulse output
      // center mode forces every channel not set to off into pulse output
      always_ff @(posedge clk) begin
        if (reset) begin
          cfg_q[gi] <= '0;
        end else if (ctl_wr) begin
          cfg_q[gi].irq_en <= reg_wdata[`TPU_CH_IE];
          cfg_q[gi].mode <= tpu_pkg::tpu_mode_type'(
            reg_wdata[`TPU_CH_MODE_MSB:`TPU_CH_MODE_LSB]);
          cfg_q[gi].sel <= reg_wdata[`TPU_CH_SEL_MSB:`TPU_CH_SEL_LSB];
        end
      end

      tpu_pkg::tpu_chcfg_type eff_cfg;
      assign eff_cfg.irq_en = cfg_q[gi].irq_en;
      assign eff_cfg.sel = cfg_q[gi].sel;
      assign eff_cfg.mode = (center_q &&
        cfg_q[gi].mode != tpu_pkg::TPU_CH_OFF) ?
        tpu_pkg::TPU_CH_PWM : cfg_q[gi].mode;

      tpu_channel u_ch (
        .clk(clk),
        .reset(reset),
        .tm(tm),
        .cfg(eff_cfg),
        .val_wr(val_wr),
        .wdata(reg_wdata),
        .flag_clr(ctl_wr && reg_wdata[`TPU_CH_FLAG]),
        .pin_in(ch_pin_in[gi]),
        .val_q(ch_val[gi]),
        .flag_q(ch_flag[gi]),
        .irq_q(ch_irq[gi]),
        .pin_out_q(ch_pin_out[gi]),
        .pin_oe_n_q(ch_pin_oe_n[gi])
      );
    end
  endgenerate

  assign channel_irq_q = ch_irq;

  // ============================================================
  // Read data, one cycle after the strobe; unmapped reads give zero
  logic [15:0] ctrl_word;
  logic [15:0] ch_ctl_word;
  logic [15:0] rd_mux;
  tpu_pkg::tpu_chcfg_type sel_cfg;
  logic [2:0] sel_idx;
  assign sel_idx = slot[2:0];
  assign sel_cfg = ch_hit ? cfg_q[sel_idx] : '0;
  assign ctrl_word = {8'h00, ovf_flag_q, ovf_ie_q, center_q,
                      src_q, ps_q};
  assign ch_ctl_word = {8'h00, ch_flag[sel_idx], sel_cfg.irq_en, 2'h0,
                        sel_cfg.sel, sel_cfg.mode};
  assign rd_mux = (reg_addr == `TPU_ADDR_CTRL) ? ctrl_word :
                  (reg_addr == `TPU_ADDR_COUNT) ? count_q :
                  (reg_addr == `TPU_ADDR_MOD) ? mod_q :
                  (ch_hit && !reg_addr[0]) ? ch_ctl_word :
                  (ch_hit) ? ch_val[sel_idx] : `TPU_WORD_ZERO;

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata_q <= `TPU_WORD_ZERO;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end else begin
      reg_rdata_q <= `TPU_WORD_ZERO;
    end
  end

endmodule
`default_nettype wire

// ### tpu_timer_assertions.sv
// Port checks for the timer unit
`timescale 1ns/1ps
`default_nettype none
module tpu_timer_assert #(
  parameter int CHANNELS = 5,
  parameter int PINNED = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata_q,
  input wire logic [PINNED-1:0] timer_channel_pin_out,
  input wire logic [PINNED-1:0] timer_channel_pin_oe_n,
  input wire logic [CHANNELS-1:0] channel_irq_q,
  input wire logic overflow_irq_q
);
  // ==========
  // Checks, one clock domain
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // Modulus write, one idle cycle, then a read of it
  sequence mod_wr_s;
    reg_wr && reg_addr == 8'h02;
  endsequence
  sequence mod_rd_s;
    reg_rd && reg_addr == 8'h02;
  endsequence
  AST_MOD_READ: assert property (mod_wr_s ##1 !reg_wr ##1 mod_rd_s |=>
    reg_rdata_q == $past(reg_wdata, 3)) else $error("modulus readback");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata_q == 16'h0000)
    else $error("read data outside its slot");
  AST_RD_HOLE: assert property (reg_rd && reg_addr == 8'h03 |=>
    reg_rdata_q == 16'h0000) else $error("unmapped read not zero");
  AST_RESET_PINS: assert property ($fell(reset) |->
    &timer_channel_pin_oe_n && timer_channel_pin_out == '0 &&
    channel_irq_q == '0 && !overflow_irq_q) else $error("pins after reset");
  // Released enables silence interrupts; three cycles cover the pipeline
  AST_OVF_IRQ_OFF: assert property (reg_wr && reg_addr == 8'h00 &&
    !reg_wdata[6] |-> ##3 !overflow_irq_q) else $error("overflow irq");
  AST_CH_IRQ_OFF: assert property (reg_wr && reg_addr == 8'h04 &&
    !reg_wdata[6] |-> ##3 !channel_irq_q[0]) else $error("channel irq");
  AST_OE_RELEASE: assert property (reg_wr && reg_addr == 8'h04 &&
    reg_wdata[1:0] == 2'b00 |-> ##3 timer_channel_pin_oe_n[0])
    else $error("pin kept after channel off");
  AST_OE_DRIVE: assert property (reg_wr && reg_addr == 8'h04 &&
    reg_wdata[1:0] == 2'b10 |-> ##3 !timer_channel_pin_oe_n[0])
    else $error("compare pin not driven");
endmodule
bind tpu_timer tpu_timer_assert #(.CHANNELS(CHANNELS), .PINNED(PINNED)) chk_u (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .timer_channel_pin_out(timer_channel_pin_out),
  .timer_channel_pin_oe_n(timer_channel_pin_oe_n),
  .channel_irq_q(channel_irq_q), .overflow_irq_q(overflow_irq_q));
`default_nettype wire

// ### tpu_pin_model.sv
// Far side of the timer: channel pins, reference and count clocks
`timescale 1ns/1ps
`default_nettype none
module tpu_pin_model #(
  parameter int PINNED = 4
) (
  input wire logic clk,
  input wire logic [PINNED-1:0] pin_out,
  input wire logic [PINNED-1:0] pin_oe_n,
  output logic [PINNED-1:0] pin_in,
  output logic ref_clk,
  output logic ext_clk
);
  logic [PINNED-1:0] drv_en = '0;
  logic [PINNED-1:0] drv_val = '0;
  // ==========
  // Pin wires
  // shared pin level
  // Port pull-up holds the line when neither side drives it
  always_comb begin
    for (int i = 0; i < PINNED; i++) begin
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (drv_en[i] ? drv_val[i] : 1'b1);
    end
  end
  // reference keeps running
  // Free-running oscillator, so the fixed clock choice stays legal
  initial begin
    ref_clk = 1'b0;
    #13;
    forever #160 ref_clk = ~ref_clk;
  end
  initial ext_clk = 1'b0;
  // Drive one pin, then hold long enough for the synchroniser
  task automatic drive(input int i, input logic v);
    @(posedge clk);
    drv_en[i] <= 1'b1;
    drv_val[i] <= v;
    repeat (6) @(posedge clk);
  endtask
  // External count pulses, three cycles high and four low between pulses
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      ext_clk <= 1'b1;
      repeat (3) @(posedge clk);
      ext_clk <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ### tpu_timer_test.sv
// Self-checking bench for the timer unit
`timescale 1ns/1ps
`default_nettype none
module tpu_timer_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata_q;
  logic [3:0] pin_in;
  logic [3:0] pin_out;
  logic [3:0] pin_oe_n;
  logic [4:0] channel_irq_q;
  logic overflow_irq_q;
  logic ref_clk;
  logic ext_clk;
  logic [15:0] got;
  logic [15:0] prev;
  logic bit0;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int hi;
  // ==========
  // Clock, design and far side
  always #20 clk = ~clk;
  tpu_timer #(.CHANNELS(5), .PINNED(4)) dut_u (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .external_reference_clock(ref_clk), .ext_clock_pin(ext_clk),
    .timer_channel_pin_in(pin_in), .timer_channel_pin_out(pin_out),
    .timer_channel_pin_oe_n(pin_oe_n), .channel_irq_q(channel_irq_q),
    .overflow_irq_q(overflow_irq_q));
  tpu_pin_model #(.PINNED(4)) pm_u (
    .clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in),
    .ref_clk(ref_clk), .ext_clk(ext_clk));
  // ==========
  // Access and compare tasks
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata_q;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    rd(a);
    check(got, e);
  endtask
  // Count advance over d cycles; exact whatever the prescaler phase
  task automatic span(input int d, input logic [15:0] e);
    rd(8'h01);
    prev = got;
    repeat (d - 2) @(posedge clk);
    rd(8'h01);
    check(got - prev, e);
  endtask
  // Up mode wraps with a big drop, center mode steps back down
  task automatic sweep(input int c);
    int big, down, top, d;
    big = 0;
    down = 0;
    top = 0;
    rd(8'h01);
    prev = got;
    repeat (20) begin
      rd(8'h01);
      d = int'(got) - int'(prev);
      if (d < -2) big++;
      if (d < 0 && d >= -2) down++;
      if (int'(got) > top) top = int'(got);
      prev = got;
    end
    check(16'(top <= 9), 16'h0001);
    check(16'(c ? big == 0 && down > 0 : big > 0 && down == 0), 16'h0001);
  endtask
  task automatic ones(input int n);
    hi = 0;
    repeat (n) begin
      @(posedge clk);
      #1 hi += int'(pin_out[0]);
    end
  endtask
  // Clear flag, arm edge select s, then a rise and a fall
  task automatic cap(input logic [1:0] s);
    wr(8'h06, {8'h00, 4'h8, s, 2'b01});
    pm_u.drive(1, 1'b1);
    rd(8'h06);
    check(16'(got[7]), 16'(s != 2'd2));
    wr(8'h06, {8'h00, 4'h8, s, 2'b01});
    pm_u.drive(1, 1'b0);
    rd(8'h06);
    check(16'(got[7]), 16'(s != 2'd1));
  endtask
  task automatic summarize();
    if (fails == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Cycle ceiling cuts a hung run short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("BAD %0t timeout", $time);
      summarize();
    end
  end
  // ==========
  // Test sequence
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rdc(8'h00, 16'h0000);
    rdc(8'h02, 16'hffff);
    wr(8'h03, 16'h1234);
    rdc(8'h03, 16'h0000);
    for (int n = 0; n < 8; n++) begin
      wr(8'h00, 16'h0008 | 16'(n));
      wr(8'h01, 16'h0000);
      span(4 << n, 16'h0004);
    end
    // Source off so the new modulus loads at once
    wr(8'h00, 16'h0000);
    wr(8'h02, 16'h0009);
    rdc(8'h02, 16'h0009);
    for (int c = 0; c < 2; c++) begin
      wr(8'h00, c ? 16'h0028 : 16'h0008);
      wr(8'h01, 16'h0000);
      sweep(c);
    end
    rd(8'h00);
    check(16'(got[7]), 16'h0001);
    wr(8'h00, 16'h0068);
    repeat (4) @(posedge clk);
    #1 check(16'(overflow_irq_q), 16'h0001);
    wr(8'h00, 16'h0028);
    wr(8'h00, 16'h0008);
    wr(8'h05, 16'h0005);
    for (int s = 0; s < 2; s++) begin
      wr(8'h04, s ? 16'h000a : 16'h000e);
      repeat (25) @(posedge clk);
      #1 check({15'h0000, pin_out[0]}, 16'(s == 0));
      check({15'h0000, pin_oe_n[0]}, 16'h0000);
    end
    wr(8'h04, 16'h0046);
    repeat (20) @(posedge clk);
    #1 bit0 = pin_out[0];
    repeat (10) @(posedge clk);
    #1 check(16'(pin_out[0] !== bit0), 16'h0001);
    rd(8'h04);
    check(16'(got[7]), 16'h0001);
    check(16'(channel_irq_q[0]), 16'h0001);
    wr(8'h04, 16'h0006);
    for (int s = 0; s < 2; s++) begin
      wr(8'h05, 16'h0004);
      wr(8'h04, s ? 16'h0003 : 16'h0007);
      repeat (25) @(posedge clk);
      ones(10);
      check(16'(hi), s ? 16'h0006 : 16'h0004);
    end
    // Center bit turns a compare channel into pulse output
    wr(8'h00, 16'h0028);
    wr(8'h04, 16'h0006);
    repeat (40) @(posedge clk);
    ones(18);
    check(16'(hi), 16'h0007);
    wr(8'h04, 16'h0000);
    wr(8'h00, 16'h0000);
    wr(8'h02, 16'hffff);
    wr(8'h00, 16'h0008);
    pm_u.drive(1, 1'b0);
    wr(8'h01, 16'h0000);
    cap(2'd1);
    rd(8'h07);
    check(16'(got >= 16'h0003 && got <= 16'h000a), 16'h0001);
    cap(2'd2);
    cap(2'd3);
    wr(8'h00, 16'h0018);
    wr(8'h01, 16'h0000);
    pm_u.pulses(5);
    rdc(8'h01, 16'h0005);
    wr(8'h00, 16'h0010);
    span(160, 16'h000a);
    @(posedge clk);
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rdc(8'h02, 16'hffff);
    rdc(8'h00, 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
